// ==== shared/backlight_defines.svh ====
`ifndef BACKLIGHT_DEFINES_SVH
`define BACKLIGHT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MODE_CONTROL_ADDR 8'h01
`define FAULT_STATUS_ADDR 8'h02
`define FAULT_IRQ_ENABLE_ADDR 8'h03
`define BACKLIGHT_CONFIG_ADDR 8'h04
`define SINK_GROUP_SELECT_ADDR 8'h05
`define OFF_TIMEOUT_ADDR 8'h06
`define DIM_TIMEOUT_ADDR 8'h07

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MODE_GROUP_ON_BIT 0
`define MODE_DIM_BIT 4
`define FAULT_OVERLOAD_BIT 4
`define FAULT_THERMAL_BIT 3
`define FAULT_OVERVOLTAGE_BIT 2
`define CONFIG_FADE_OVR_BIT 0
`define CONFIG_LAW_LSB 1
`define CONFIG_LAW_MSB 2
`define TIMEOUT_MSB 6
`define SINK_SEL_MSB 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TIMEOUT_RESET 7'h00
`define SINK_SEL_RESET 7'h00
`define LAW_RESET 2'h0
`define FLAGS_RESET 3'h0

// ----------------------------------------------------------------
// Timing and default target address
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define ONE_SECOND_NS 1000000000
`define TARGET_ADDR_DEFAULT 7'h2A

`endif

// ==== shared/backlight_pkg.sv ====
package backlight_pkg;

  // Backlight timeout sequencer
  typedef enum logic [2:0] {
    TMR_OFF = 3'b000,
    TMR_WAIT_MAX = 3'b001,
    TMR_DIM_COUNT = 3'b010,
    TMR_OFF_COUNT = 3'b011,
    TMR_HOLD = 3'b100
  } timer_state_t;

  // Serial target states
  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_ADDR = 3'b001,
    SER_REG = 3'b010,
    SER_WDATA = 3'b011,
    SER_RDATA = 3'b100,
    SER_RACK = 3'b101,
    SER_GAP = 3'b110
  } ser_state_t;

  typedef enum logic [1:0] {
    LAW_LINEAR = 2'b00,
    LAW_SQUARE = 2'b01,
    LAW_CUBIC_10 = 2'b10,
    LAW_CUBIC_11 = 2'b11
  } law_t;

endpackage

// ==== rtl/serial_target.sv ====
`timescale 1ns/100ps
`include "backlight_defines.svh"

module serial_target #(
  parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Two-wire pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Register side
  output logic [7:0] reg_ptr,
  input wire logic [7:0] reg_rdata,
  output logic wr_pulse,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    backlight_pkg::ser_state_t state;
    backlight_pkg::ser_state_t after;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [3:0] bitcnt;
    logic [7:0] ptr;
    logic drive;
    logic wr;
    logic [7:0] waddr;
    logic [7:0] wdata;
  } ser_t;

  ser_t r_reg;
  ser_t r_next;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = r_reg.scl_s2 & ~r_reg.scl_d;
  assign scl_fall = ~r_reg.scl_s2 & r_reg.scl_d;
  // Edges on the data line while the clock is high frame a transfer
  assign start_seen = r_reg.scl_s2 & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s2;
  assign stop_seen = r_reg.scl_s2 & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s2;

  always_comb begin
    r_next = r_reg;
    r_next.scl_s1 = scl_in;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_d = r_reg.scl_s2;
    r_next.sda_s1 = sda_in;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_d = r_reg.sda_s2;
    r_next.wr = 1'b0;
    if (start_seen) begin
      r_next.state = backlight_pkg::SER_ADDR;
      r_next.bitcnt = 4'h0;
      r_next.drive = 1'b0;
    end else if (stop_seen) begin
      r_next.state = backlight_pkg::SER_IDLE;
      r_next.drive = 1'b0;
    end else begin
      case (r_reg.state)
        backlight_pkg::SER_ADDR, backlight_pkg::SER_REG, backlight_pkg::SER_WDATA: begin
          if (scl_rise) begin
            r_next.shreg = {r_reg.shreg[6:0], r_reg.sda_s2};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (scl_fall && r_reg.bitcnt == 4'h8) begin
            r_next.drive = 1'b1;
            r_next.state = backlight_pkg::SER_GAP;
            if (r_reg.state == backlight_pkg::SER_ADDR) begin
              if (r_reg.shreg[7:1] != TARGET_ADDR) begin
                r_next.drive = 1'b0;
                r_next.state = backlight_pkg::SER_IDLE;
              end
              r_next.after = r_reg.shreg[0] ? backlight_pkg::SER_RDATA
                                            : backlight_pkg::SER_REG;
            end else if (r_reg.state == backlight_pkg::SER_REG) begin
              r_next.ptr = r_reg.shreg;
              r_next.after = backlight_pkg::SER_WDATA;
            end else begin
              r_next.wr = 1'b1;
              r_next.waddr = r_reg.ptr;
              r_next.wdata = r_reg.shreg;
              r_next.ptr = r_reg.ptr + 8'h01;
              r_next.after = backlight_pkg::SER_WDATA;
            end
          end
        end
        backlight_pkg::SER_GAP: begin
          // Acknowledge clock ends; either hand over to the next byte or load read data
          if (scl_fall) begin
            r_next.bitcnt = 4'h0;
            r_next.drive = 1'b0;
            r_next.state = r_reg.after;
            if (r_reg.after == backlight_pkg::SER_RDATA) begin
              r_next.tx = reg_rdata;
              r_next.drive = ~reg_rdata[7];
              r_next.ptr = r_reg.ptr + 8'h01;
            end
          end
        end
        backlight_pkg::SER_RDATA: begin
          if (scl_rise) begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (r_reg.bitcnt == 4'h8) begin
              r_next.drive = 1'b0;
              r_next.state = backlight_pkg::SER_RACK;
            end else begin
              r_next.tx = {r_reg.tx[6:0], 1'b0};
              r_next.drive = ~r_reg.tx[6];
            end
          end
        end
        backlight_pkg::SER_RACK: begin
          // Controller not-acknowledge ends the read burst
          if (scl_rise) begin
            r_next.state = r_reg.sda_s2 ? backlight_pkg::SER_IDLE : backlight_pkg::SER_GAP;
            r_next.after = backlight_pkg::SER_RDATA;
          end
        end
        backlight_pkg::SER_IDLE: begin
          r_next.drive = 1'b0;
        end
        default: begin
          r_next.state = backlight_pkg::SER_IDLE;
          r_next.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_reg <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                 sda_d: 1'b1, state: backlight_pkg::SER_IDLE,
                 after: backlight_pkg::SER_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = r_reg.drive;
  assign reg_ptr = r_reg.ptr;
  assign wr_pulse = r_reg.wr;
  assign wr_addr = r_reg.waddr;
  assign wr_data = r_reg.wdata;

endmodule

// ==== rtl/backlight_config_registers.sv ====
// Operation
// - Overload flag raises host interrupt only when overload enable bit 4 is set.
// - Thermal flag raises host interrupt only when thermal enable bit 3 is set.
// - Overvoltage flag raises host interrupt only when overvoltage enable bit 2 is set.
// - A cleared enable masks the interrupt only; flags still set and hold.
// - Interrupt enable bits 7:5 and 1:0 are reserved, no function.
// - Law field bits 2:1: 00 linear DAC/linear time, 01 square/linear time.
// - Law codes 10 and 11 select square DAC with two cubic time profiles.
// - Config bit 0 enables fade override; bits 7:3 reserved.
// - Sink-select bit n-1 set makes LED n an independent sink.
// - Sink-select bit clear puts LED in backlight group; bit 7 reserved.
// - Off timeout 6:0 switches backlight off on expiry; zero disables; seconds.
// - With a nonzero dim timeout, off countdown starts after dim expiry.
// - Dim timeout starts at maximum current, then dims; zero disables.
// - Fault flags clear only on write of 1; reads and zeros leave them.
// - Hardware sets dim bit on dim expiry; dim acts only with group on.
`timescale 1ns/100ps
`include "backlight_defines.svh"

module backlight_config_registers #(
  parameter int CYCLES_PER_SEC = `ONE_SECOND_NS / `CLK_PERIOD_NS,
  parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Two-wire serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Fault detectors (asynchronous levels)
  input wire logic fault_overload,
  input wire logic fault_thermal,
  input wire logic fault_overvoltage,
  // Fade engine status
  input wire logic backlight_at_max,
  // Host interrupt
  output logic host_irq,
  // Backlight control outputs
  output logic backlight_group_on,
  output logic dim_active,
  output logic [1:0] transfer_law,
  output logic fade_override_enable,
  output logic [6:0] led_independent_select,
  output logic [6:0] led_group_enable
);

  localparam int CW = $clog2(CYCLES_PER_SEC);

  typedef struct packed {
    logic [2:0] fault_s1;
    logic [2:0] fault_s2;
    logic [2:0] flags;
    logic [2:0] irq_en;
    logic group_on;
    logic dim;
    logic [1:0] law;
    logic fade_ovr;
    logic [6:0] sink_sel;
    logic [6:0] off_secs;
    logic [6:0] dim_secs;
    backlight_pkg::timer_state_t tstate;
    logic [CW-1:0] tick_cnt;
    logic [6:0] secs_left;
  } state_t;

  state_t r_reg;
  state_t r_next;
  logic [7:0] reg_ptr;
  logic [7:0] rdata;
  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic sec_tick;
  logic [2:0] clr_mask;

  // ----------------------------------------------------------------
  // Serial register access
  // ----------------------------------------------------------------
  serial_target #(
    .TARGET_ADDR(TARGET_ADDR)
  ) u_serial (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_ptr(reg_ptr),
    .reg_rdata(rdata),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata = 8'h00;
    case (reg_ptr)
      `MODE_CONTROL_ADDR: begin
        rdata[`MODE_GROUP_ON_BIT] = r_reg.group_on;
        rdata[`MODE_DIM_BIT] = r_reg.dim;
      end
      `FAULT_STATUS_ADDR: begin
        rdata[`FAULT_OVERLOAD_BIT:`FAULT_OVERVOLTAGE_BIT] = r_reg.flags;
      end
      `FAULT_IRQ_ENABLE_ADDR: begin
        rdata[`FAULT_OVERLOAD_BIT:`FAULT_OVERVOLTAGE_BIT] = r_reg.irq_en;
      end
      `BACKLIGHT_CONFIG_ADDR: begin
        rdata[`CONFIG_LAW_MSB:`CONFIG_LAW_LSB] = r_reg.law;
        rdata[`CONFIG_FADE_OVR_BIT] = r_reg.fade_ovr;
      end
      `SINK_GROUP_SELECT_ADDR: begin
        rdata[`SINK_SEL_MSB:0] = r_reg.sink_sel;
      end
      `OFF_TIMEOUT_ADDR: begin
        rdata[`TIMEOUT_MSB:0] = r_reg.off_secs;
      end
      `DIM_TIMEOUT_ADDR: begin
        rdata[`TIMEOUT_MSB:0] = r_reg.dim_secs;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register and sequencer next state
  // ----------------------------------------------------------------
  assign sec_tick = (r_reg.tick_cnt == CW'(CYCLES_PER_SEC - 1));

  always_comb begin
    r_next = r_reg;
    clr_mask = 3'h0;
    r_next.fault_s1 = {fault_overload, fault_thermal, fault_overvoltage};
    r_next.fault_s2 = r_reg.fault_s1;

    if (wr_pulse) begin
      case (wr_addr)
        `MODE_CONTROL_ADDR: begin
          r_next.group_on = wr_data[`MODE_GROUP_ON_BIT];
          r_next.dim = wr_data[`MODE_DIM_BIT];
        end
        `FAULT_STATUS_ADDR: begin
          clr_mask = wr_data[`FAULT_OVERLOAD_BIT:`FAULT_OVERVOLTAGE_BIT];
        end
        `FAULT_IRQ_ENABLE_ADDR: begin
          r_next.irq_en = wr_data[`FAULT_OVERLOAD_BIT:`FAULT_OVERVOLTAGE_BIT];
        end
        `BACKLIGHT_CONFIG_ADDR: begin
          r_next.law = wr_data[`CONFIG_LAW_MSB:`CONFIG_LAW_LSB];
          r_next.fade_ovr = wr_data[`CONFIG_FADE_OVR_BIT];
        end
        `SINK_GROUP_SELECT_ADDR: begin
          r_next.sink_sel = wr_data[`SINK_SEL_MSB:0];
        end
        `OFF_TIMEOUT_ADDR: begin
          r_next.off_secs = wr_data[`TIMEOUT_MSB:0];
        end
        `DIM_TIMEOUT_ADDR: begin
          r_next.dim_secs = wr_data[`TIMEOUT_MSB:0];
        end
        default: begin
        end
      endcase
    end

    // A fault present in the clearing cycle keeps its flag: set wins over clear
    r_next.flags = (r_reg.flags & ~clr_mask) | r_reg.fault_s2;

    // One-second timebase runs only while a timeout is counting
    if (r_reg.tstate == backlight_pkg::TMR_DIM_COUNT
        || r_reg.tstate == backlight_pkg::TMR_OFF_COUNT) begin
      r_next.tick_cnt = sec_tick ? '0 : r_reg.tick_cnt + CW'(1);
      if (sec_tick) begin
        r_next.secs_left = r_reg.secs_left - 7'h01;
      end
    end else begin
      r_next.tick_cnt = '0;
    end

    case (r_reg.tstate)
      backlight_pkg::TMR_OFF: begin
        if (r_next.group_on) begin
          r_next.tstate = backlight_pkg::TMR_WAIT_MAX;
        end
      end
      backlight_pkg::TMR_WAIT_MAX: begin
        if (backlight_at_max) begin
          if (r_reg.dim_secs != 7'h00) begin
            r_next.tstate = backlight_pkg::TMR_DIM_COUNT;
            r_next.secs_left = r_reg.dim_secs;
          end else if (r_reg.off_secs != 7'h00) begin
            r_next.tstate = backlight_pkg::TMR_OFF_COUNT;
            r_next.secs_left = r_reg.off_secs;
          end else begin
            r_next.tstate = backlight_pkg::TMR_HOLD;
          end
        end
      end
      backlight_pkg::TMR_DIM_COUNT: begin
        if (sec_tick && r_reg.secs_left == 7'h01) begin
          r_next.dim = 1'b1;
          r_next.tick_cnt = '0;
          if (r_reg.off_secs != 7'h00) begin
            r_next.tstate = backlight_pkg::TMR_OFF_COUNT;
            r_next.secs_left = r_reg.off_secs;
          end else begin
            r_next.tstate = backlight_pkg::TMR_HOLD;
          end
        end
      end
      backlight_pkg::TMR_OFF_COUNT: begin
        if (sec_tick && r_reg.secs_left == 7'h01) begin
          r_next.group_on = 1'b0;
          r_next.dim = 1'b0;
          r_next.tstate = backlight_pkg::TMR_OFF;
        end
      end
      backlight_pkg::TMR_HOLD: begin
      end
      default: begin
        r_next.tstate = backlight_pkg::TMR_OFF;
      end
    endcase

    // Switching the group off by software abandons any countdown
    if (!r_next.group_on) begin
      r_next.tstate = backlight_pkg::TMR_OFF;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_reg <= '{flags: `FLAGS_RESET, law: `LAW_RESET, sink_sel: `SINK_SEL_RESET,
                 off_secs: `TIMEOUT_RESET, dim_secs: `TIMEOUT_RESET,
                 tstate: backlight_pkg::TMR_OFF, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_irq = |(r_reg.flags & r_reg.irq_en);
  assign backlight_group_on = r_reg.group_on;
  // Dim bit may be held while the group is off, but only acts with it on
  assign dim_active = r_reg.dim & r_reg.group_on;
  assign transfer_law = r_reg.law;
  assign fade_override_enable = r_reg.fade_ovr;
  assign led_independent_select = r_reg.sink_sel;
  assign led_group_enable = ~r_reg.sink_sel & {7{r_reg.group_on}};

endmodule

// ==== tb/serial_host_model.sv ====
`timescale 1ns/100ps
module serial_host_model #(
  parameter logic [6:0] TARGET_ADDR = 7'h2A
) (
  // Clock
  input wire logic clk_sys,
  // Bus wires; sda_pull high pulls the data line low
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  int nack_count = 0;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Four clocks low, four high: SCL period of 400 ns, data moves only while SCL is low
  task automatic bit_cycle(input logic pull, output logic b);
    scl = 1'b0;
    tick(2);
    sda_pull = pull;
    tick(2);
    scl = 1'b1;
    tick(2);
    b = sda_line;
    tick(2);
  endtask

  // Start when first is 0, stop when first is 1
  task automatic edge_cond(input logic first);
    scl = 1'b0;
    tick(2);
    sda_pull = first;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = ~first;
    tick(4);
  endtask

  // Releasing the line in the ack slot also serves as the closing no-ack of a read
  task automatic xfer(input logic [7:0] d, input logic drive, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(drive & ~d[i], q[i]);
    end
    bit_cycle(1'b0, a);
    if (drive && a !== 1'b0) begin
      nack_count++;
    end
  endtask

  task automatic access(input logic [7:0] ptr, input logic do_read, inout logic [7:0] d);
    logic [7:0] q;
    edge_cond(1'b0);
    xfer({TARGET_ADDR, 1'b0}, 1'b1, q);
    xfer(ptr, 1'b1, q);
    if (do_read) begin
      edge_cond(1'b0);
      xfer({TARGET_ADDR, 1'b1}, 1'b1, q);
      xfer(8'hFF, 1'b0, d);
    end else begin
      xfer(d, 1'b1, q);
    end
    edge_cond(1'b1);
  endtask
endmodule

// ==== tb/backlight_config_registers_assertions.sv ====
`timescale 1ns/100ps
module backlight_config_registers_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Fault and fade inputs
  input wire logic fault_overload,
  input wire logic fault_thermal,
  input wire logic fault_overvoltage,
  input wire logic backlight_at_max,
  // Outputs
  input wire logic host_irq,
  input wire logic backlight_group_on,
  input wire logic dim_active,
  input wire logic [1:0] transfer_law,
  input wire logic fade_override_enable,
  input wire logic [6:0] led_independent_select,
  input wire logic [6:0] led_group_enable
);
  // Host writes land a few clocks after SCL low, so 16 quiet clocks rule them out
  logic [4:0] quiet_reg;
  logic fault_seen_reg;
  logic max_seen_reg;
  logic bus_quiet;
  logic any_fault;
  assign bus_quiet = quiet_reg[4];
  assign any_fault = fault_overload | fault_thermal | fault_overvoltage;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !scl_in) begin
      quiet_reg <= 5'h00;
    end else if (!bus_quiet) begin
      quiet_reg <= quiet_reg + 5'h01;
    end
    fault_seen_reg <= rst_n & (fault_seen_reg | any_fault);
    max_seen_reg <= rst_n & backlight_group_on & (max_seen_reg | backlight_at_max);
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_hw_dim;
    $rose(dim_active) && bus_quiet;
  endsequence
  sequence s_hw_off;
    $fell(backlight_group_on) && bus_quiet;
  endsequence

  property p_group_members;
    led_group_enable == (~led_independent_select & {7{backlight_group_on}});
  endproperty
  property p_dim_in_group;
    dim_active |-> backlight_group_on;
  endproperty
  property p_irq_cause;
    host_irq |-> fault_seen_reg;
  endproperty
  property p_irq_clear;
    $fell(host_irq) |-> !bus_quiet;
  endproperty
  property p_select_hold;
    $changed(led_independent_select) |-> !bus_quiet;
  endproperty
  property p_law_hold;
    bus_quiet [*2] |-> $stable(transfer_law);
  endproperty
  property p_dim_after_max;
    s_hw_dim |-> max_seen_reg;
  endproperty
  property p_off_after_max;
    s_hw_off |-> max_seen_reg ##1 !dim_active;
  endproperty

  a_group_members: assert property (p_group_members) else $error("group enables wrong");
  a_dim_in_group: assert property (p_dim_in_group) else $error("dim without group");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without fault");
  a_irq_clear: assert property (p_irq_clear) else $error("irq dropped alone");
  a_select_hold: assert property (p_select_hold) else $error("select changed alone");
  a_law_hold: assert property (p_law_hold) else $error("law changed alone");
  a_dim_after_max: assert property (p_dim_after_max) else $error("dim before max");
  a_off_after_max: assert property (p_off_after_max) else $error("off before max");
endmodule

bind backlight_config_registers backlight_config_registers_assertions u_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .fault_overload(fault_overload), .fault_thermal(fault_thermal),
  .fault_overvoltage(fault_overvoltage), .backlight_at_max(backlight_at_max),
  .host_irq(host_irq), .backlight_group_on(backlight_group_on), .dim_active(dim_active),
  .transfer_law(transfer_law), .fade_override_enable(fade_override_enable),
  .led_independent_select(led_independent_select), .led_group_enable(led_group_enable));

// ==== tb/backlight_config_registers_tb.sv ====
`timescale 1ns/100ps
module backlight_config_registers_tb;
  localparam int SEC = 20;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic scl_in;
  logic sda_pull;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic [2:0] fault_vec = 3'h0;
  logic at_max = 1'b0;
  logic host_irq;
  logic group_on;
  logic dim_active;
  logic [1:0] law;
  logic fade_ovr;
  logic [6:0] indep;
  logic [6:0] grp_en;
  logic [7:0] rd;
  int miscompares = 0;
  int cmp_count = 0;

  always #25 clk_sys = ~clk_sys;
  // Open-drain data line with a pull-up
  assign sda_in = ~sda_pull & (sda_oe ? sda_out : 1'b1);

  serial_host_model host (
    .clk_sys(clk_sys), .scl(scl_in), .sda_pull(sda_pull), .sda_line(sda_in));

  backlight_config_registers #(.CYCLES_PER_SEC(SEC)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .fault_overload(fault_vec[2]), .fault_thermal(fault_vec[1]),
    .fault_overvoltage(fault_vec[0]), .backlight_at_max(at_max), .host_irq(host_irq),
    .backlight_group_on(group_on), .dim_active(dim_active), .transfer_law(law),
    .fade_override_enable(fade_ovr), .led_independent_select(indep), .led_group_enable(grp_en));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.access(p, 1'b0, d);
  endtask

  task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
    host.access(p, 1'b1, rd);
    chk(rd, exp);
  endtask

  // Counter latency is not fixed to the clock, so allow a small window
  task automatic near(input int n, input int exp);
    chk({7'h00, (n >= exp - 2) && (n <= exp + 4)}, 8'h01);
  endtask

  task automatic count_to(input bit sel, input logic lvl, output int n);
    n = 0;
    while ((sel ? group_on : dim_active) !== lvl) begin
      tick(1);
      n++;
      if (n > 400) begin
        chk({7'h00, ~lvl}, {7'h00, lvl});
        close_out();
      end
    end
  endtask

  task automatic t_reset();
    chk({1'b0, host_irq, group_on, dim_active, law, fade_ovr, sda_oe}, 8'h00);
    for (int a = 4; a <= 7; a++) begin
      rdc(8'(a), 8'h00);
    end
    $display("reset test done");
  endtask

  task automatic t_config();
    logic [7:0] v;
    for (int c = 0; c < 8; c++) begin
      v = {5'h1F, 3'(c)};
      wr(8'h04, v);
      chk({6'h00, law}, {6'h00, v[2:1]});
      chk({7'h00, fade_ovr}, {7'h00, v[0]});
      rdc(8'h04, {5'h00, v[2:0]});
    end
    $display("config test done");
  endtask

  task automatic t_sink();
    wr(8'h05, 8'hA5);
    rdc(8'h05, 8'h25);
    chk({1'b0, indep}, 8'h25);
    chk({1'b0, grp_en}, 8'h00);
    wr(8'h01, 8'h01);
    chk({1'b0, grp_en}, 8'h5A);
    wr(8'h05, 8'h7F);
    chk({1'b0, grp_en}, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h30, 8'hFF);
    rdc(8'h30, 8'h00);
    $display("sink test done");
  endtask

  task automatic t_faults();
    logic [7:0] m;
    for (int k = 0; k < 3; k++) begin
      m = 8'h04 << k;
      wr(8'h03, ~m);
      rdc(8'h03, ~m & 8'h1C);
      fault_vec[k] = 1'b1;
      tick(10);
      fault_vec[k] = 1'b0;
      tick(4);
      chk({7'h00, host_irq}, 8'h00);
      rdc(8'h02, m);
      wr(8'h02, ~m);
      rdc(8'h02, m);
      wr(8'h03, m);
      chk({7'h00, host_irq}, 8'h01);
      wr(8'h02, m);
      chk({7'h00, host_irq}, 8'h00);
      rdc(8'h02, 8'h00);
    end
    $display("fault test done");
  endtask

  task automatic pulse_max();
    tick(30);
    at_max = 1'b1;
    tick(1);
    at_max = 1'b0;
  endtask

  task automatic t_timeout();
    int n;
    wr(8'h07, 8'h02);
    wr(8'h06, 8'h83);
    rdc(8'h06, 8'h03);
    rdc(8'h07, 8'h02);
    wr(8'h01, 8'h01);
    pulse_max();
    count_to(1'b0, 1'b1, n);
    near(n, 2 * SEC);
    count_to(1'b1, 1'b0, n);
    near(n, 3 * SEC);
    wr(8'h07, 8'h00);
    wr(8'h01, 8'h01);
    pulse_max();
    count_to(1'b1, 1'b0, n);
    near(n, 3 * SEC);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h01);
    wr(8'h01, 8'h01);
    pulse_max();
    count_to(1'b0, 1'b1, n);
    near(n, SEC);
    tick(200);
    chk({7'h00, group_on}, 8'h01);
    rdc(8'h01, 8'h11);
    wr(8'h01, 8'h10);
    chk({7'h00, dim_active}, 8'h00);
    wr(8'h01, 8'h00);
    $display("timeout test done");
  endtask

  initial begin
    tick(2);
    rst_n = 1'b1;
    tick(4);
    t_reset();
    t_config();
    t_sink();
    t_faults();
    t_timeout();
    chk(8'(host.nack_count), 8'h00);
    close_out();
  end
endmodule
